// file: rtl/ldm_pkg.sv
// constants for the led driver status and configuration map
// shared by the top module and the bench; the only logic is the period decode
package ldm_pkg;
  // channel and word sizes
  localparam int N_CH = 24;
  localparam int GRP_CH = 8;
  localparam int CFG_W = 216;
  localparam int SID_W = 288;
  localparam int DC_W = 7;
  // field positions inside the 288-bit word
  localparam int DC_LSB = 0;
  localparam int DC_MSB = 167;
  localparam int BC_LSB = 168;
  localparam int BC_W = 24;
  localparam int FC_LSB = 192;
  localparam int FC_W = 7;
  localparam int UD_LSB = 199;
  localparam int UD_W = 17;
  localparam int RSV_W = 23;
  localparam int TEF_BIT = 239;
  localparam int SHORT_LSB = 240;
  localparam int OPEN_LSB = 264;
  // function control bits, relative to FC_LSB
  localparam int FC_RANGE = 0;
  localparam int FC_AUTO = 3;
  localparam int FC_DTR = 4;
  localparam int FC_MODE = 5;
  // timing in colour grayscale clock pulses
  localparam logic [12:0] FLAG_CAPTURE = 13'h0021;
  localparam logic [12:0] PERIOD_12 = 13'h1000;
  localparam logic [12:0] PERIOD_10 = 13'h0400;
  localparam logic [12:0] PERIOD_8 = 13'h0100;
  localparam logic [12:0] FIRST_PULSE = 13'h0001;
  // synchroniser lanes for the link pins
  localparam int PIN_BLANK = 0;
  localparam int PIN_LAT = 1;
  localparam int PIN_GCK = 2;
  localparam int PIN_SCK = 5;
  localparam int PIN_W = 6;
  // register map, word indices (byte address bits 7:2)
  localparam int CFG_WORDS = 7;
  localparam logic [5:0] IDX_STAT = 6'h07;
  localparam logic [5:0] IDX_SHORT = 6'h08;
  localparam logic [5:0] IDX_OPEN = 6'h09;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // output on-time period for the counter mode field
  function automatic logic [12:0] period(input logic [1:0] mode);
    if (!mode[1]) begin
      return PERIOD_12;
    end
    return mode[0] ? PERIOD_8 : PERIOD_10;
  endfunction
endpackage

// file: rtl/ldm_top.sv
// status and configuration side of a 24-channel constant-current led driver
// assumes an axi4-lite master on sys_clk and a display controller whose link
// pins and comparator levels are asynchronous to sys_clk
//
// Summary of operation
// - 7-bit trim per channel, bits 0..167
// - 8-bit brightness per colour, bits 168..191
// - function control field at bits 198..192
// - 17-bit user field, no effect
// - bits 238..216 reserved, read as zero
// - thermal flag at bit 239, one hot
// - short flags at bits 240..263
// - open flags at bits 264..287
// - capture flags at 33rd colour pulse
// - over-temperature sets flag, outputs off
// - shutdown lasts until cool and new cycle
// - flag clears on latch pulse when cool
// - outputs return at next period first pulse
// - internal release equals external blanking release
// - four staggered sub-groups per colour
// - each colour timed by its own clock
// - status loads on latch, shifts out serially
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
module ldm_top (
  // system
  input wire logic sys_clk,
  input wire logic rst,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // display link pins
  input wire logic blanking_n_input,
  input wire logic grayscale_latch_pulse,
  input wire logic [2:0] colour_grayscale_clocks,
  input wire logic grayscale_shift_clock,
  output logic grayscale_serial_out,
  // analogue side
  input wire logic [23:0] open_cmp_in,
  input wire logic [23:0] short_cmp_in,
  input wire logic over_temp_in,
  output logic [23:0] channel_on,
  output logic [167:0] per_channel_current_trim,
  output logic [23:0] group_brightness,
  output logic [2:0] dc_high_range
);

  typedef struct packed {
    logic [5:0] p1;
    logic [5:0] p2;
    logic [5:0] p3;
    logic [48:0] a1;
    logic [48:0] a2;
    logic [215:0] cfg;
    logic thermal_error_flag;
    logic thermal_shutdown;
    logic [2:0] run;
    logic [2:0] act;
    logic [2:0][12:0] cnt;
    logic [2:0][3:0] stg;
    logic [23:0] on;
    logic [23:0] opn;
    logic [23:0] sht;
    logic [287:0] sr;
    logic sout;
    logic aw_h;
    logic w_h;
    logic [7:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic awr;
    logic wr;
    logic bv;
    logic [1:0] br;
    logic arr;
    logic rv;
    logic [1:0] rr;
    logic [31:0] rd;
  } ldm_state_s;

  ldm_state_s q;
  ldm_state_s d;

  // register read mux; unmapped words read zero with an error response
  function automatic logic [31:0] rd_word(input ldm_state_s s, input logic [5:0] idx);
    logic [223:0] padded;
    padded = {8'h00, s.cfg};
    if (int'(idx) < ldm_pkg::CFG_WORDS) begin
      return padded[int'(idx) * 32 +: 32];
    end
    case (idx)
      ldm_pkg::IDX_STAT: return {24'h000000, s.act, s.run, s.thermal_shutdown, s.thermal_error_flag};
      ldm_pkg::IDX_SHORT: return {8'h00, s.sht};
      ldm_pkg::IDX_OPEN: return {8'h00, s.opn};
      default: return 32'h00000000;
    endcase
  endfunction

  // next-state logic for the whole block
  always_comb begin
    logic [5:0] rise;
    logic ot;
    logic blank_hi;
    logic rel;
    logic auto_on;
    logic [12:0] n;
    logic [12:0] per;
    int base;
    n = '0;
    base = 0;
    d = q;
    // two-stage synchronisers; the edge detect looks only at p2 and p3
    d.p1 = {grayscale_shift_clock, colour_grayscale_clocks, grayscale_latch_pulse,
            blanking_n_input};
    d.p2 = q.p1;
    d.p3 = q.p2;
    d.a1 = {over_temp_in, short_cmp_in, open_cmp_in};
    d.a2 = q.a1;
    rise = q.p2 & ~q.p3;
    ot = q.a2[48];
    blank_hi = q.p2[ldm_pkg::PIN_BLANK];
    auto_on = q.cfg[ldm_pkg::FC_LSB + ldm_pkg::FC_AUTO];
    per = ldm_pkg::period(q.cfg[ldm_pkg::FC_LSB + ldm_pkg::FC_MODE +: 2]);
    // latch with timing reset behaves as a blanking pulse and release
    rel = rise[ldm_pkg::PIN_BLANK] |
          (rise[ldm_pkg::PIN_LAT] & q.cfg[ldm_pkg::FC_LSB + ldm_pkg::FC_DTR]);

    // thermal flag: a hot sample beats the latch clear
    if (ot) begin
      d.thermal_error_flag = 1'b1;
      d.thermal_shutdown = 1'b1;
    end else if (rise[ldm_pkg::PIN_LAT]) begin
      d.thermal_error_flag = 1'b0;
    end
    // shutdown releases only at a new cycle start while cool
    if (rel && !ot) begin
      d.thermal_shutdown = 1'b0;
    end

    // per colour display timing, each from its own clock
    for (int g = 0; g < 3; g++) begin
      if (!blank_hi && !rel) begin
        d.run[g] = 1'b0;
        d.act[g] = 1'b0;
        d.cnt[g] = '0;
      end else if (rel) begin
        d.run[g] = 1'b1;
        d.act[g] = 1'b0;
        d.cnt[g] = '0;
      end else if (q.run[g] && rise[ldm_pkg::PIN_GCK + g]) begin
        n = q.cnt[g] + ldm_pkg::FIRST_PULSE;
        d.cnt[g] = n;
        if (n == ldm_pkg::FIRST_PULSE) begin
          d.act[g] = !q.thermal_shutdown;
        end
        if (n == ldm_pkg::FLAG_CAPTURE) begin
          d.opn[g * ldm_pkg::GRP_CH +: 8] = q.a2[g * ldm_pkg::GRP_CH +: 8];
          d.sht[g * ldm_pkg::GRP_CH +: 8] = q.a2[ldm_pkg::N_CH + g * 8 +: 8];
        end
        if (n == per) begin
          d.act[g] = 1'b0;
          if (auto_on) begin
            d.cnt[g] = '0;
            if (!ot) begin
              d.thermal_shutdown = 1'b0;
            end
          end else begin
            d.run[g] = 1'b0;
          end
        end
      end
      if (ot) begin
        d.act[g] = 1'b0;
      end
      // one sys_clk step between sub-groups keeps inrush down
      d.stg[g] = {q.stg[g][2:0], q.act[g]};
      for (int k = 0; k < 4; k++) begin
        d.on[g * 8 + k] = q.stg[g][k] & ~d.thermal_shutdown;
        d.on[g * 8 + k + 4] = q.stg[g][k] & ~d.thermal_shutdown;
      end
    end

    // status readback: reserved bits forced to zero
    if (rise[ldm_pkg::PIN_LAT]) begin
      d.sr = {q.opn, q.sht, q.thermal_error_flag, {ldm_pkg::RSV_W{1'b0}}, q.cfg};
    end else if (rise[ldm_pkg::PIN_SCK]) begin
      d.sr = {q.sr[ldm_pkg::SID_W - 2:0], 1'b0};
    end
    d.sout = d.sr[ldm_pkg::SID_W - 1];

    // axi write: address and data held independently
    if (s_axi_awvalid && q.awr) begin
      d.aw_h = 1'b1;
      d.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wr) begin
      d.w_h = 1'b1;
      d.w_d = s_axi_wdata;
      d.w_s = s_axi_wstrb;
    end
    if (q.bv && s_axi_bready) begin
      d.bv = 1'b0;
    end
    if (q.aw_h && q.w_h && !q.bv) begin
      d.aw_h = 1'b0;
      d.w_h = 1'b0;
      d.bv = 1'b1;
      d.br = ldm_pkg::RESP_SLVERR;
      if (int'(q.aw_a[7:2]) < ldm_pkg::CFG_WORDS) begin
        d.br = ldm_pkg::RESP_OKAY;
        for (int b = 0; b < 4; b++) begin
          base = int'(q.aw_a[7:2]) * 32 + b * 8;
          if (q.w_s[b] && base < ldm_pkg::CFG_W) begin
            d.cfg[base +: 8] = q.w_d[b * 8 +: 8];
          end
        end
      end
    end
    d.awr = !d.aw_h && !d.bv;
    d.wr = !d.w_h && !d.bv;

    // axi read: one outstanding, answered the cycle after the address
    if (q.rv && s_axi_rready) begin
      d.rv = 1'b0;
    end
    if (s_axi_arvalid && q.arr) begin
      d.rv = 1'b1;
      d.rd = rd_word(q, s_axi_araddr[7:2]);
      d.rr = (s_axi_araddr[7:2] > ldm_pkg::IDX_OPEN) ? ldm_pkg::RESP_SLVERR
                                                     : ldm_pkg::RESP_OKAY;
    end
    d.arr = !d.rv;

    if (rst) begin
      d = '0;
    end
  end

  // the single state register
  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  // outputs straight from the state register
  assign s_axi_awready = q.awr;
  assign s_axi_wready = q.wr;
  assign s_axi_bvalid = q.bv;
  assign s_axi_bresp = q.br;
  assign s_axi_arready = q.arr;
  assign s_axi_rvalid = q.rv;
  assign s_axi_rdata = q.rd;
  assign s_axi_rresp = q.rr;
  assign grayscale_serial_out = q.sout;
  assign channel_on = q.on;
  assign per_channel_current_trim = q.cfg[ldm_pkg::DC_MSB:ldm_pkg::DC_LSB];
  assign group_brightness = q.cfg[ldm_pkg::BC_LSB +: ldm_pkg::BC_W];
  assign dc_high_range = q.cfg[ldm_pkg::FC_LSB + ldm_pkg::FC_RANGE +: 3];
endmodule // ldm_top

// file: tb/ldm_top_assertions.sv
// checker for ldm_top: bus answer timing, thermal off, staggered turn-on
// assumes a bind onto ldm_top with matching port names
`timescale 1ns/10ps
module ldm_top_assertions (
  // system
  input wire logic sys_clk,
  input wire logic rst,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analogue side
  input wire logic over_temp_in,
  input wire logic [23:0] channel_on,
  input wire logic [167:0] per_channel_current_trim,
  input wire logic [23:0] group_brightness,
  input wire logic [2:0] dc_high_range
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // red turn-on walks the sub-groups one cycle apart to spread inrush
  sequence s_stagger;
    channel_on[4] && !channel_on[1] ##1 channel_on[5] && !channel_on[2]
    ##1 channel_on[6] && !channel_on[3] ##1 channel_on[7];
  endsequence
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_wr_answer:
    assert property (s_both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("b timing");
  a_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("r timing");
  a_b_stands:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("b dropped");
  a_r_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("r dropped");
  a_ready_gap:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready early");
  a_hot_off:
    assert property (over_temp_in [*6] |-> channel_on == 24'h000000) else $error("hot but on");
  a_sub_groups:
    assert property ($rose(channel_on[0]) |-> !channel_on[1] ##0 s_stagger) else $error("stagger");
  a_cfg_commit:
    assert property (!$stable({per_channel_current_trim, group_brightness, dc_high_range})
      |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("config moved without write");
endmodule // ldm_top_assertions

// file: tb/ldm_ctrl_model.sv
// display controller model: pulses link pins at a 125 ns rate, reads status
// assumes the driver samples pins on its own clock; clocks idle low
`timescale 1ns/10ps
module ldm_ctrl_model (
  // pins to the driver
  output logic blank_n,
  output logic lat,
  output logic [2:0] gck,
  output logic sck,
  // readback
  input wire logic sout
);
  logic [4:0] pins = 5'h00;
  int gck_seen = 0;
  logic flags_ok = 1'b0;
  // clocks stand still between frames, so nothing is counted by accident
  assign {sck, lat, gck} = pins;
  initial blank_n = 1'b0;
  task automatic set_blank(input logic v);
    blank_n = v;
    if (!v) gck_seen = 0;
    // let the release settle so the first colour pulse is not swallowed by it
    if (v) #100;
  endtask
  // one pulse on the chosen pins {sck, lat, gck}
  task automatic tick(input logic [4:0] m);
    pins = m;
    #62.5;
    pins = 5'h00;
    #62.5;
    if (m[0]) gck_seen++;
    flags_ok = (gck_seen >= 33); // flags trusted only after capture
  endtask
  // latch, then shift the status word out msb first
  task automatic read_sid(output logic [287:0] v);
    tick(5'h08);
    v[287] = sout;
    for (int i = 286; i >= 0; i--) begin
      tick(5'h10);
      v[i] = sout;
    end
  endtask
endmodule // ldm_ctrl_model

// file: tb/led_driver_status_config_map_tb.sv
// bench for ldm_top: register map, flag capture, serial readback, thermal
// assumes ldm_pkg, ldm_ctrl_model and the checker are compiled first
`timescale 1ns/10ps
module led_driver_status_config_map_tb;
  localparam logic [23:0] P_OPEN = 24'hA5C3F0;
  localparam logic [23:0] P_SHORT = 24'h0F1E2D;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, over_temp_in = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [23:0] open_cmp_in = P_OPEN, short_cmp_in = P_SHORT;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic grayscale_serial_out, blanking_n_input, grayscale_latch_pulse, grayscale_shift_clock;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [23:0] channel_on, group_brightness;
  logic [167:0] per_channel_current_trim;
  logic [2:0] dc_high_range, colour_grayscale_clocks;
  logic [31:0] cfg [7];
  logic [223:0] flat;
  logic [287:0] status_readback_word;
  int err_total = 0, n_compared = 0;
  ldm_top u_dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .blanking_n_input, .grayscale_latch_pulse, .colour_grayscale_clocks,
    .grayscale_shift_clock, .grayscale_serial_out, .open_cmp_in, .short_cmp_in, .over_temp_in,
    .channel_on, .per_channel_current_trim, .group_brightness, .dc_high_range);
  ldm_ctrl_model u_ctl (.blank_n(blanking_n_input), .lat(grayscale_latch_pulse),
    .gck(colour_grayscale_clocks), .sck(grayscale_shift_clock), .sout(grayscale_serial_out));
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [287:0] got, input logic [287:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bus tasks: hold each channel until taken, response ready raised together with valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, er);
    chk(s_axi_rdata & m, e);
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin : watchdog
    #300000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    // config words; top byte of word 6 lies above the map and is dropped
    for (int n = 0; n < 6; n++) cfg[n] = 32'h13579BDF + 32'(n) * 32'h11111111;
    cfg[6] = 32'h00C5A787; // function bits 198:195 stay zero
    for (int n = 0; n < 7; n++) flat[32*n +: 32] = cfg[n];
    for (int n = 0; n < 7; n++) wr(8'(4 * n), cfg[n] | {8'(n / 6) * 8'hFF, 24'h0}, 2'h0);
    for (int n = 0; n < 7; n++) rd(8'(4 * n), cfg[n], 32'hFFFFFFFF, 2'h0);
    chk(per_channel_current_trim, flat[167:0]);
    chk(group_brightness, flat[191:168]);
    chk(dc_high_range, flat[194:192]);
    wr(8'h1C, 32'hFFFFFFFF, ldm_pkg::RESP_SLVERR);
    rd(8'h28, 32'h0, 32'hFFFFFFFF, ldm_pkg::RESP_SLVERR);
    // only byte lane 1 enabled: the other lanes of word 0 must stay put
    s_axi_wstrb <= 4'h2;
    wr(8'h00, 32'hFFFFFFFF, 2'h0);
    s_axi_wstrb <= 4'hF;
    flat[15:8] = 8'hFF;
    rd(8'h00, flat[31:0], 32'hFFFFFFFF, 2'h0);
    $display("test registers done");
    u_ctl.set_blank(1'b1);
    repeat (33) u_ctl.tick(5'h07);
    chk(u_ctl.flags_ok, 1'b1);
    rd(8'h20, {8'h00, P_SHORT}, 32'hFFFFFFFF, 2'h0);
    open_cmp_in <= 24'h000000;
    short_cmp_in <= 24'h000000;
    u_ctl.tick(5'h07);
    rd(8'h24, {8'h00, P_OPEN}, 32'hFFFFFFFF, 2'h0);
    u_ctl.read_sid(status_readback_word);
    chk(status_readback_word, {P_OPEN, P_SHORT, 1'b0, 23'h0, flat[215:0]});
    $display("test flags done");
    chk(channel_on, 24'hFFFFFF);
    @(posedge sys_clk);
    over_temp_in <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk(channel_on, 24'h000000);
    rd(8'h1C, 32'h3, 32'h3, 2'h0);
    over_temp_in <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rd(8'h1C, 32'h3, 32'h3, 2'h0);
    u_ctl.tick(5'h08);
    rd(8'h1C, 32'h0, 32'h1, 2'h0);
    chk(channel_on, 24'h000000);
    u_ctl.set_blank(1'b0);
    #500;
    u_ctl.set_blank(1'b1);
    #500;
    chk(channel_on, 24'h000000);
    u_ctl.tick(5'h01);
    chk(channel_on, 24'h0000FF);
    u_ctl.tick(5'h06);
    chk(channel_on, 24'hFFFFFF);
    $display("test thermal done");
    wrap_up();
  end
endmodule // led_driver_status_config_map_tb
bind ldm_top ldm_top_assertions u_chk (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .over_temp_in, .channel_on,
  .per_channel_current_trim, .group_brightness, .dc_high_range);
